// ### rtl/setst_consts.vh
// constants and register map for the serial event timing block
// Function
// - uart double buffer: receive interrupt near middle of first stop bit
// - sync mode: receive interrupt right after last selected shift clock edge
// - sync double buffer: receive interrupt when buffer read pulls pending word
// - no receive interrupt for a frame that overran
// - uart single buffer: transmit interrupt on the same clock edge that starts the stop bit
// - sync single buffer: transmit interrupt right after last selected clock edge
// - double buffer: transmit interrupt on every buffer to shifter move
// - double buffer: interrupt also when a write moves straight into idle shifter
// - uart: framing and overrun flags set near middle of stop bit
// - parity checked mid parity bit, flagged mid stop bit; none for 9 bits
// - sync mode: overrun flagged right after last selected clock edge
// - sync mode: underrun flagged after next frame edge, via parity flag
// - overrun and underrun meaningless when this block drives the clock
// - soft reset only after writing code 10 then code 01
// - soft reset clears enables, buffer flags, running, errors, engines idle
// - sync clock out, single buffer: each write sends one word, then interrupt
// - sync clock out, double: move on idle write or finish, flag, interrupt
// - sync clock out, double: nothing buffered at finish stops clock, no interrupt
// - sync clock in, single: on clock shift eight bits, then interrupt
// - sync clock in, double: move on early write or finish, flag, interrupt
// - clock starts with empty buffer: count bits, underrun, send all ones
// - external clock: each transmit bit changes on the selected edge
`ifndef SETST_CONSTS_VH
`define SETST_CONSTS_VH
`define SETST_OFF_CTRL 8'h00
`define SETST_OFF_STATUS 8'h04
`define SETST_OFF_SOFT_RESET_CODE 8'h08
`define SETST_OFF_TXDATA 8'h0c
`define SETST_OFF_RXDATA 8'h10
`define SETST_OFF_DIV 8'h14
`define SETST_CTRL_MODE_LO 0
`define SETST_CTRL_MODE_HI 1
`define SETST_CTRL_DBUF 2
`define SETST_CTRL_EDGE 3
`define SETST_CTRL_CLKIN 4
`define SETST_CTRL_PAREN 5
`define SETST_CTRL_PAREVEN 6
`define SETST_CTRL_RXEN 7
`define SETST_CTRL_TXEN 8
`define SETST_ST_TX_BUFFER_EMPTY_FLAG 0
`define SETST_ST_RBFULL 1
`define SETST_ST_RUN 2
`define SETST_ST_OVR 3
`define SETST_ST_PARITY_UNDERRUN_ERROR_FLAG 4
`define SETST_ST_FRAMING_ERROR_FLAG 5
`define SETST_MODE_SYNC 2'h0
`define SETST_MODE_UART7 2'h1
`define SETST_MODE_UART8 2'h2
`define SETST_MODE_UART9 2'h3
`define SETST_SWR_ARM 2'h2
`define SETST_SWR_FIRE 2'h1
`define SETST_DIV_RESET 16'h000c
`define SETST_SUB_MID 4'h7
`define SETST_SUB_LAST 4'hf
`define SETST_SYNC_LAST 4'h7
`define SETST_FILL 9'h1ff
`define SETST_MASK7 9'h07f
`define SETST_MASK8 9'h0ff
`define SETST_MASK9 9'h1ff
`endif

// ### rtl/setst_core.v
// serial channel: uart and clocked shift modes with apb registers
`timescale 1ns/1ps
`include "setst_consts.vh"
module setst_core #(
  parameter DIV_W = 16
) (
  input wire clock,
  input wire rst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire serial_in_pin,
  output wire serial_out_pin,
  input wire shift_clock_in,
  output wire shift_clock_out,
  output wire shift_clock_oe_n,
  output reg transmit_interrupt,
  output reg receive_interrupt
);
  localparam T_IDLE = 3'h0;
  localparam T_START = 3'h1;
  localparam T_DATA = 3'h2;
  localparam T_PAR = 3'h3;
  localparam T_STOP = 3'h4;

  // control register fields
  reg [1:0] mode_reg;
  reg double_buffer_enable;
  reg clock_edge_select;
  reg clk_in_reg;
  reg par_en_reg;
  reg par_even_reg;
  reg rx_enable_bit;
  reg tx_enable_bit;
  reg [DIV_W-1:0] div_reg;
  reg [DIV_W-1:0] div_cnt_reg;
  reg swr_arm_reg;
  reg sw_rst_reg;
  // status flags
  reg tx_buffer_empty_flag;
  reg rx_buffer_full_flag;
  reg overrun_error_flag;
  reg parity_underrun_error_flag;
  reg framing_error_flag;
  // transmit side
  reg [8:0] tx_buf_reg;
  reg tx_buf_valid_reg;
  reg [8:0] tx_sh_reg;
  reg tx_loaded_reg;
  reg tx_dummy_reg;
  reg tx_out_reg;
  reg [2:0] tx_state_reg;
  reg [3:0] tx_sub_reg;
  reg [3:0] tx_idx_reg;
  reg sclk_reg;
  reg [3:0] sbit_cnt_reg;
  // receive side
  reg [2:0] rx_state_reg;
  reg [3:0] rx_sub_reg;
  reg [3:0] rx_idx_reg;
  reg [8:0] rx_sh_reg;
  reg parity_underrun_error_flag_pend_reg;
  reg [8:0] rx_buf_reg;
  reg [8:0] rx_pend_reg;
  reg rx_pend_valid_reg;
  reg [31:0] rdata_next;
  reg mapped;

  wire sclk_level;
  wire sclk_rise;
  wire sclk_fall;
  wire sin_level;

  setst_sync u_sclk_sync (
    .clock(clock),
    .rst(rst),
    .async_in(shift_clock_in),
    .level(sclk_level),
    .rise(sclk_rise),
    .fall(sclk_fall)
  );

  setst_sync u_sin_sync (
    .clock(clock),
    .rst(rst),
    .async_in(serial_in_pin),
    .level(sin_level),
    .rise(),
    .fall()
  );

  // bus decode
  wire wr = psel & penable & pwrite;
  wire rd = psel & penable & ~pwrite;
  wire wr_ctrl = wr && (paddr == `SETST_OFF_CTRL);
  wire wr_status = wr && (paddr == `SETST_OFF_STATUS);
  wire wr_swr = wr && (paddr == `SETST_OFF_SOFT_RESET_CODE);
  wire wr_tx = wr && (paddr == `SETST_OFF_TXDATA);
  wire wr_div = wr && (paddr == `SETST_OFF_DIV);
  wire rd_rx = rd && (paddr == `SETST_OFF_RXDATA);

  // mode decode
  wire sync_mode = (mode_reg == `SETST_MODE_SYNC);
  wire uart_mode = ~sync_mode;
  wire sync_act = sync_mode & (tx_enable_bit | rx_enable_bit);
  wire has_par = par_en_reg & (mode_reg != `SETST_MODE_UART9);
  wire [8:0] mask = (mode_reg == `SETST_MODE_UART7) ? `SETST_MASK7 :
                    (mode_reg == `SETST_MODE_UART8) ? `SETST_MASK8 : `SETST_MASK9;
  wire [3:0] last_idx = (mode_reg == `SETST_MODE_UART7) ? 4'h6 :
                        (mode_reg == `SETST_MODE_UART8) ? 4'h7 : 4'h8;
  wire tick = (div_cnt_reg == {DIV_W{1'b0}});

  // shift clock edges, generated or taken from the peer
  wire gen_ok = sync_mode & ~clk_in_reg & tx_enable_bit & tick & (tx_loaded_reg | ~sclk_reg);
  wire ext_shift = clock_edge_select ? sclk_rise : sclk_fall;
  wire ext_sample = clock_edge_select ? sclk_fall : sclk_rise;
  wire shift_ev = sync_act & (clk_in_reg ? ext_shift : (gen_ok & sclk_reg));
  wire sample_ev = sync_act & (clk_in_reg ? ext_sample : (gen_ok & ~sclk_reg));
  wire frame_done = sample_ev & (sbit_cnt_reg == `SETST_SYNC_LAST);

  // completion events
  wire uart_tx_done = uart_mode & tick & (tx_state_reg == T_STOP) & (tx_sub_reg == `SETST_SUB_LAST);
  wire tx_done = (frame_done & tx_enable_bit & tx_loaded_reg) | uart_tx_done;
  wire tx_direct = ~tx_loaded_reg | (tx_done & ~tx_buf_valid_reg);
  wire urun_set = shift_ev & tx_enable_bit & clk_in_reg &
                  (sbit_cnt_reg == 4'h0) & ~tx_loaded_reg;
  wire tx_par = (^(tx_sh_reg & mask)) ^ ~par_even_reg;
  wire stop_mid = uart_mode & rx_enable_bit & tick & (rx_state_reg == T_STOP) &
                  (rx_sub_reg == `SETST_SUB_MID);
  wire sync_rx_done = frame_done & rx_enable_bit;
  wire rx_done = sync_rx_done | stop_mid;
  wire [8:0] rx_word = sync_rx_done ? {1'b0, sin_level, rx_sh_reg[7:1]} : (rx_sh_reg & mask);
  wire full_eff = rx_buffer_full_flag & ~(rd_rx & ~rx_pend_valid_reg);
  wire pend_eff = rx_pend_valid_reg & ~rd_rx;
  wire rx_to_buf = rx_done & ~full_eff;
  wire rx_to_pend = rx_done & full_eff & ~pend_eff & double_buffer_enable & sync_mode;
  wire ovr_set = rx_done & ~rx_to_buf & ~rx_to_pend & ~(sync_mode & ~clk_in_reg);
  wire framing_error_flag_set = stop_mid & ~sin_level;
  wire parity_underrun_error_flag_set = (stop_mid & has_par & parity_underrun_error_flag_pend_reg) | urun_set;

  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;
  assign serial_out_pin = tx_out_reg;
  assign shift_clock_out = sclk_reg;
  assign shift_clock_oe_n = ~(sync_mode & ~clk_in_reg);

  // read mux, sampled in the setup cycle
  always @* begin
    rdata_next = 32'h0000_0000;
    mapped = 1'b1;
    if (paddr == `SETST_OFF_CTRL) begin
      rdata_next[`SETST_CTRL_MODE_HI:`SETST_CTRL_MODE_LO] = mode_reg;
      rdata_next[`SETST_CTRL_DBUF] = double_buffer_enable;
      rdata_next[`SETST_CTRL_EDGE] = clock_edge_select;
      rdata_next[`SETST_CTRL_CLKIN] = clk_in_reg;
      rdata_next[`SETST_CTRL_PAREN] = par_en_reg;
      rdata_next[`SETST_CTRL_PAREVEN] = par_even_reg;
      rdata_next[`SETST_CTRL_RXEN] = rx_enable_bit;
      rdata_next[`SETST_CTRL_TXEN] = tx_enable_bit;
    end else if (paddr == `SETST_OFF_STATUS) begin
      rdata_next[`SETST_ST_TX_BUFFER_EMPTY_FLAG] = tx_buffer_empty_flag;
      rdata_next[`SETST_ST_RBFULL] = rx_buffer_full_flag;
      rdata_next[`SETST_ST_RUN] = tx_loaded_reg | (tx_state_reg != T_IDLE);
      rdata_next[`SETST_ST_OVR] = overrun_error_flag;
      rdata_next[`SETST_ST_PARITY_UNDERRUN_ERROR_FLAG] = parity_underrun_error_flag;
      rdata_next[`SETST_ST_FRAMING_ERROR_FLAG] = framing_error_flag;
    end else if (paddr == `SETST_OFF_SOFT_RESET_CODE) begin
      rdata_next[1] = swr_arm_reg;
    end else if (paddr == `SETST_OFF_TXDATA) begin
      rdata_next[8:0] = tx_buf_reg;
    end else if (paddr == `SETST_OFF_RXDATA) begin
      rdata_next[8:0] = rx_buf_reg;
    end else if (paddr == `SETST_OFF_DIV) begin
      rdata_next[DIV_W-1:0] = div_reg;
    end else begin
      mapped = 1'b0;
    end
  end

  always @(posedge clock or posedge rst) begin
    if (rst) begin
      prdata <= 32'h0000_0000;
    end else if (psel & ~penable) begin
      prdata <= rdata_next;
    end
  end

  // control registers, soft reset sequence and baud divider
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      mode_reg <= `SETST_MODE_SYNC;
      double_buffer_enable <= 1'b0;
      clock_edge_select <= 1'b0;
      clk_in_reg <= 1'b0;
      par_en_reg <= 1'b0;
      par_even_reg <= 1'b0;
      rx_enable_bit <= 1'b0;
      tx_enable_bit <= 1'b0;
      div_reg <= `SETST_DIV_RESET;
      div_cnt_reg <= {DIV_W{1'b0}};
      swr_arm_reg <= 1'b0;
      sw_rst_reg <= 1'b0;
    end else begin
      sw_rst_reg <= 1'b0;
      div_cnt_reg <= tick ? div_reg : div_cnt_reg - 1'b1;
      if (wr_ctrl) begin
        mode_reg <= pwdata[`SETST_CTRL_MODE_HI:`SETST_CTRL_MODE_LO];
        double_buffer_enable <= pwdata[`SETST_CTRL_DBUF];
        clock_edge_select <= pwdata[`SETST_CTRL_EDGE];
        clk_in_reg <= pwdata[`SETST_CTRL_CLKIN];
        par_en_reg <= pwdata[`SETST_CTRL_PAREN];
        par_even_reg <= pwdata[`SETST_CTRL_PAREVEN];
        rx_enable_bit <= pwdata[`SETST_CTRL_RXEN];
        tx_enable_bit <= pwdata[`SETST_CTRL_TXEN];
      end
      if (wr_div) begin
        div_reg <= pwdata[DIV_W-1:0];
      end
      if (wr_swr) begin
        if (pwdata[1:0] == `SETST_SWR_ARM) begin
          swr_arm_reg <= 1'b1;
        end else begin
          swr_arm_reg <= 1'b0;
          sw_rst_reg <= swr_arm_reg & (pwdata[1:0] == `SETST_SWR_FIRE);
        end
      end
      if (sw_rst_reg) begin
        rx_enable_bit <= 1'b0;
        tx_enable_bit <= 1'b0;
      end
    end
  end

  // error flags: write one clears, a set in the same cycle wins
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      overrun_error_flag <= 1'b0;
      parity_underrun_error_flag <= 1'b0;
      framing_error_flag <= 1'b0;
    end else if (sw_rst_reg) begin
      overrun_error_flag <= 1'b0;
      parity_underrun_error_flag <= 1'b0;
      framing_error_flag <= 1'b0;
    end else begin
      if (wr_status & pwdata[`SETST_ST_OVR]) overrun_error_flag <= 1'b0;
      if (wr_status & pwdata[`SETST_ST_PARITY_UNDERRUN_ERROR_FLAG]) parity_underrun_error_flag <= 1'b0;
      if (wr_status & pwdata[`SETST_ST_FRAMING_ERROR_FLAG]) framing_error_flag <= 1'b0;
      if (ovr_set) overrun_error_flag <= 1'b1;
      if (parity_underrun_error_flag_set) parity_underrun_error_flag <= 1'b1;
      if (framing_error_flag_set) framing_error_flag <= 1'b1;
    end
  end

  // transmit engine: buffer, shifter, shift clock, uart framing
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      tx_buf_reg <= 9'h000;
      tx_buf_valid_reg <= 1'b0;
      tx_buffer_empty_flag <= 1'b0;
      tx_sh_reg <= `SETST_FILL;
      tx_loaded_reg <= 1'b0;
      tx_dummy_reg <= 1'b0;
      tx_out_reg <= 1'b1;
      tx_state_reg <= T_IDLE;
      tx_sub_reg <= 4'h0;
      tx_idx_reg <= 4'h0;
      sclk_reg <= 1'b1;
      sbit_cnt_reg <= 4'h0;
      transmit_interrupt <= 1'b0;
    end else begin
      transmit_interrupt <= 1'b0;
      if (sw_rst_reg) begin
        tx_buf_valid_reg <= 1'b0;
        tx_buffer_empty_flag <= 1'b0;
        tx_loaded_reg <= 1'b0;
        tx_dummy_reg <= 1'b0;
        tx_out_reg <= 1'b1;
        tx_state_reg <= T_IDLE;
        sclk_reg <= 1'b1;
        sbit_cnt_reg <= 4'h0;
      end else begin
        if (gen_ok) begin
          sclk_reg <= ~sclk_reg;
        end
        if (sample_ev) begin
          sbit_cnt_reg <= frame_done ? 4'h0 : sbit_cnt_reg + 4'h1;
        end
        if (shift_ev & tx_enable_bit) begin
          if (sbit_cnt_reg == 4'h0) begin
            if (tx_loaded_reg) begin
              tx_out_reg <= tx_sh_reg[0];
            end else begin
              tx_out_reg <= 1'b1;
              tx_sh_reg <= `SETST_FILL;
              tx_loaded_reg <= 1'b1;
              tx_dummy_reg <= 1'b1;
            end
          end else begin
            tx_out_reg <= tx_sh_reg[1];
            tx_sh_reg <= {1'b1, tx_sh_reg[8:1]};
          end
        end
        if (uart_mode & tick) begin
          tx_sub_reg <= tx_sub_reg + 4'h1;
          case (tx_state_reg)
            T_IDLE: begin
              tx_sub_reg <= 4'h0;
              if (tx_loaded_reg & tx_enable_bit) begin
                tx_state_reg <= T_START;
                tx_out_reg <= 1'b0;
              end
            end
            T_START: begin
              if (tx_sub_reg == `SETST_SUB_LAST) begin
                tx_state_reg <= T_DATA;
                tx_idx_reg <= 4'h0;
                tx_out_reg <= tx_sh_reg[0];
              end
            end
            T_DATA: begin
              if (tx_sub_reg == `SETST_SUB_LAST) begin
                if (tx_idx_reg != last_idx) begin
                  tx_idx_reg <= tx_idx_reg + 4'h1;
                  tx_out_reg <= tx_sh_reg[tx_idx_reg + 4'h1];
                end else if (has_par) begin
                  tx_state_reg <= T_PAR;
                  tx_out_reg <= tx_par;
                end else begin
                  tx_state_reg <= T_STOP;
                  tx_out_reg <= 1'b1;
                  transmit_interrupt <= ~double_buffer_enable;
                end
              end
            end
            T_PAR: begin
              if (tx_sub_reg == `SETST_SUB_LAST) begin
                tx_state_reg <= T_STOP;
                tx_out_reg <= 1'b1;
                transmit_interrupt <= ~double_buffer_enable;
              end
            end
            default: begin
              if (tx_sub_reg == `SETST_SUB_LAST) begin
                tx_state_reg <= T_IDLE;
              end
            end
          endcase
        end
        if (tx_done) begin
          tx_dummy_reg <= 1'b0;
          if (double_buffer_enable & tx_buf_valid_reg) begin
            tx_sh_reg <= tx_buf_reg;
            tx_buf_valid_reg <= 1'b0;
            tx_buffer_empty_flag <= 1'b1;
            transmit_interrupt <= 1'b1;
          end else begin
            tx_loaded_reg <= 1'b0;
            transmit_interrupt <= sync_mode & ~double_buffer_enable & ~tx_dummy_reg;
          end
        end
        if (wr_tx) begin
          if (double_buffer_enable) begin
            if (tx_direct) begin
              tx_sh_reg <= pwdata[8:0];
              tx_loaded_reg <= 1'b1;
              tx_buffer_empty_flag <= 1'b1;
              transmit_interrupt <= 1'b1;
            end else begin
              tx_buf_reg <= pwdata[8:0];
              tx_buf_valid_reg <= 1'b1;
              tx_buffer_empty_flag <= 1'b0;
            end
          end else if (~tx_loaded_reg | tx_done) begin
            tx_sh_reg <= pwdata[8:0];
            tx_loaded_reg <= 1'b1;
          end
        end
      end
    end
  end

  // receive engine: uart sampler, sync shifter, buffer and pending word
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      rx_state_reg <= T_IDLE;
      rx_sub_reg <= 4'h0;
      rx_idx_reg <= 4'h0;
      rx_sh_reg <= 9'h000;
      parity_underrun_error_flag_pend_reg <= 1'b0;
      rx_buf_reg <= 9'h000;
      rx_buffer_full_flag <= 1'b0;
      rx_pend_reg <= 9'h000;
      rx_pend_valid_reg <= 1'b0;
      receive_interrupt <= 1'b0;
    end else begin
      receive_interrupt <= 1'b0;
      if (sw_rst_reg) begin
        rx_state_reg <= T_IDLE;
        rx_buffer_full_flag <= 1'b0;
        rx_pend_valid_reg <= 1'b0;
      end else begin
        if (sample_ev & rx_enable_bit) begin
          rx_sh_reg[7:0] <= {sin_level, rx_sh_reg[7:1]};
        end
        if (uart_mode & rx_enable_bit & tick) begin
          rx_sub_reg <= rx_sub_reg + 4'h1;
          case (rx_state_reg)
            T_IDLE: begin
              rx_sub_reg <= 4'h0;
              if (~sin_level) begin
                rx_state_reg <= T_START;
                rx_sh_reg <= 9'h000;
              end
            end
            T_START: begin
              if ((rx_sub_reg == `SETST_SUB_MID) & sin_level) begin
                rx_state_reg <= T_IDLE;
              end else if (rx_sub_reg == `SETST_SUB_LAST) begin
                rx_state_reg <= T_DATA;
                rx_idx_reg <= 4'h0;
              end
            end
            T_DATA: begin
              if (rx_sub_reg == `SETST_SUB_MID) begin
                rx_sh_reg[rx_idx_reg] <= sin_level;
              end
              if (rx_sub_reg == `SETST_SUB_LAST) begin
                if (rx_idx_reg != last_idx) begin
                  rx_idx_reg <= rx_idx_reg + 4'h1;
                end else begin
                  rx_state_reg <= has_par ? T_PAR : T_STOP;
                end
              end
            end
            T_PAR: begin
              if (rx_sub_reg == `SETST_SUB_MID) begin
                parity_underrun_error_flag_pend_reg <= (^(rx_sh_reg & mask)) ^ sin_level ^ ~par_even_reg;
              end
              if (rx_sub_reg == `SETST_SUB_LAST) begin
                rx_state_reg <= T_STOP;
              end
            end
            default: begin
              if (rx_sub_reg == `SETST_SUB_MID) begin
                rx_state_reg <= T_IDLE;
              end
            end
          endcase
        end
        if (rd_rx) begin
          if (rx_pend_valid_reg) begin
            rx_buf_reg <= rx_pend_reg;
            rx_pend_valid_reg <= 1'b0;
            receive_interrupt <= 1'b1;
          end else begin
            rx_buffer_full_flag <= 1'b0;
          end
        end
        if (rx_to_buf) begin
          rx_buf_reg <= rx_word;
          rx_buffer_full_flag <= 1'b1;
          receive_interrupt <= 1'b1;
        end
        if (rx_to_pend) begin
          rx_pend_reg <= rx_word;
          rx_pend_valid_reg <= 1'b1;
        end
      end
    end
  end
endmodule // setst_core

// ### rtl/setst_sync.v
// two-stage synchroniser with edge detection
`timescale 1ns/1ps
module setst_sync (
  input wire clock,
  input wire rst,
  input wire async_in,
  output wire level,
  output wire rise,
  output wire fall
);
  reg meta_reg;
  reg stable_reg;
  reg prev_reg;

  always @(posedge clock or posedge rst) begin
    if (rst) begin
      meta_reg <= 1'b1;
      stable_reg <= 1'b1;
      prev_reg <= 1'b1;
    end else begin
      meta_reg <= async_in;
      stable_reg <= meta_reg;
      prev_reg <= stable_reg;
    end
  end

  assign level = stable_reg;
  assign rise = stable_reg & ~prev_reg;
  assign fall = ~stable_reg & prev_reg;
endmodule // setst_sync

// ### tb/serial_event_timing_and_sync_tx_tb_top.sv
// testbench: registers, clocked shift and uart traffic, soft reset
`timescale 1ns/1ps
module serial_event_timing_and_sync_tx_tb_top;
  reg clock, rst, psel, penable, pwrite, e, so_d, sc_d;
  reg [7:0] paddr, prx;
  reg [31:0] pwdata, q;
  reg [15:0] cap;
  wire [31:0] prdata;
  wire pready, pslverr, serial_in_pin, serial_out_pin, peer_clk, shift_clock_out;
  wire shift_clock_oe_n, transmit_interrupt, receive_interrupt;
  wire sclk_wire = shift_clock_oe_n ? peer_clk : shift_clock_out;
  integer fails, tests_run, tx_n, rx_n, rises, n0, m0;
  time t_rx, t0;
  setst_core #(.DIV_W(16)) dut_u (.clock(clock), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .serial_in_pin(serial_in_pin), .serial_out_pin(serial_out_pin),
    .shift_clock_in(sclk_wire), .shift_clock_out(shift_clock_out),
    .shift_clock_oe_n(shift_clock_oe_n), .transmit_interrupt(transmit_interrupt),
    .receive_interrupt(receive_interrupt));
  setst_peer peer_u (.serial_in_pin(serial_in_pin), .shift_clock_in(peer_clk),
    .serial_out_pin(serial_out_pin));
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  always @(posedge clock) begin
    so_d <= serial_out_pin;
    sc_d <= shift_clock_out;
    if (shift_clock_out && !sc_d) begin
      cap <= {so_d, cap[15:1]};
      rises <= rises + 1;
    end
    if (transmit_interrupt) tx_n <= tx_n + 1;
    if (receive_interrupt) begin
      rx_n <= rx_n + 1;
      t_rx <= $time;
    end
  end
  task automatic chk(input [31:0] got, input [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic apb(input wr, input [7:0] a, input [31:0] d);
    integer n;
    n = 0;
    @(posedge clock);
    {psel, pwrite, paddr, pwdata} <= {1'b1, wr, a, d};
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1 && n < 50) begin
      n++;
      @(posedge clock);
    end
    if (n == 50) begin
      fails++;
      $display("MISMATCH %0t no pready", $time);
    end
    q = prdata;
    e = pslverr;
    {psel, penable} <= 2'h0;
  endtask
  task automatic till(ref integer c, input integer k);
    integer n;
    n = 0;
    while (c < k && n < 3000) begin
      n++;
      @(posedge clock);
    end
    if (c < k) begin
      fails++;
      $display("MISMATCH %0t wait timed out", $time);
    end
  endtask
  task automatic t_regs;
    apb(0, 8'h00, 0);
    chk(q, 32'h0000_0000);
    apb(0, 8'h14, 0);
    chk(q, 32'h0000_000c);
    apb(0, 8'h18, 0);
    chk({q[30:0], e}, 32'h0000_0001);
    apb(1, 8'h14, 32'h0000_0001);
    $display("test regs done");
  endtask
  task automatic t_sync_out;
    apb(1, 8'h00, 32'h0000_0100);
    n0 = tx_n;
    apb(1, 8'h0c, 32'h0000_00a5);
    till(tx_n, n0 + 1);
    chk(cap[15:8], 8'ha5);
    chk(tx_n, n0 + 1);
    chk(shift_clock_oe_n, 0);
    $display("test sync out done");
  endtask
  task automatic t_sync_dbl;
    apb(1, 8'h00, 32'h0000_0104);
    n0 = tx_n;
    m0 = rises;
    apb(1, 8'h0c, 32'h0000_003c);
    apb(0, 8'h04, 0);
    chk(q[0], 1);
    chk(tx_n, n0 + 1);
    apb(1, 8'h0c, 32'h0000_00c3);
    till(rises, m0 + 16);
    repeat (40) @(posedge clock);
    chk(cap, 16'hc33c);
    chk(rises, m0 + 16);
    chk(tx_n, n0 + 2);
    $display("test sync double done");
  endtask
  task automatic t_sync_in;
    apb(1, 8'h00, 32'h0000_0190);
    apb(1, 8'h0c, 32'h0000_003c);
    n0 = tx_n;
    m0 = rx_n;
    peer_u.frame(8'h5a, prx);
    repeat (8) @(posedge clock);
    chk(prx, 8'h3c);
    chk(tx_n, n0 + 1);
    chk(rx_n, m0 + 1);
    apb(0, 8'h10, 0);
    chk(q[7:0], 8'h5a);
    peer_u.frame(8'h11, prx);
    repeat (8) @(posedge clock);
    apb(0, 8'h04, 0);
    chk({prx, q[4]}, {8'hff, 1'b1});
    m0 = rx_n;
    peer_u.frame(8'h22, prx);
    repeat (8) @(posedge clock);
    apb(0, 8'h04, 0);
    chk(rx_n, m0);
    chk(q[3], 1);
    $display("test sync in done");
  endtask
  task automatic t_uart;
    apb(1, 8'h00, 32'h0000_0182);
    apb(0, 8'h10, 0);
    m0 = rx_n;
    t0 = $time;
    peer_u.uart(8'h96, 1'b1);
    chk(rx_n, m0 + 1);
    chk(t_rx - t0 > 11520 && t_rx - t0 < 12800, 1);
    apb(0, 8'h10, 0);
    chk(q[7:0], 8'h96);
    peer_u.uart(8'h55, 1'b0);
    apb(0, 8'h04, 0);
    chk(q[5], 1);
    n0 = tx_n;
    t0 = $time;
    apb(1, 8'h0c, 32'h0000_0069);
    till(tx_n, n0 + 1);
    chk($time - t0 > 11520 && $time - t0 < 12000, 1);
    $display("test uart done");
  endtask
  task automatic t_soft_reset_code;
    apb(1, 8'h08, 2);
    apb(1, 8'h08, 3);
    apb(1, 8'h08, 1);
    apb(0, 8'h00, 0);
    chk(q, 32'h0000_0182);
    apb(1, 8'h08, 2);
    apb(1, 8'h08, 1);
    apb(0, 8'h00, 0);
    chk(q, 32'h0000_0002);
    apb(0, 8'h04, 0);
    chk(q[5:0], 6'h00);
    $display("test soft reset done");
  endtask
  task close_out;
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    #400000;
    fails++;
    close_out;
  end
  initial begin
    rst = 1'b0;
    {psel, penable, pwrite, paddr, pwdata, cap} = 0;
    {so_d, sc_d} = 2'h3;
    {fails, tests_run, tx_n, rx_n, rises} = 0;
    #1 rst = 1'b1;
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    t_regs;
    t_sync_out;
    t_sync_dbl;
    t_sync_in;
    t_uart;
    t_soft_reset_code;
    close_out;
  end
endmodule // serial_event_timing_and_sync_tx_tb_top
bind setst_core setst_checker chk_u (.clock(clock), .rst(rst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .serial_out_pin(serial_out_pin), .shift_clock_out(shift_clock_out),
  .shift_clock_oe_n(shift_clock_oe_n), .transmit_interrupt(transmit_interrupt),
  .receive_interrupt(receive_interrupt));

// ### tb/setst_checker.sv
// port assertions for the serial channel
`timescale 1ns/1ps
module setst_checker (
  input wire clock,
  input wire rst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire serial_out_pin,
  input wire shift_clock_out,
  input wire shift_clock_oe_n,
  input wire transmit_interrupt,
  input wire receive_interrupt
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  wire acc = psel && penable;
  wire mapped = (paddr <= 8'h14) && (paddr[1:0] == 2'h0);
  chk_ready_high: assert property (pready)
    else $error("pready low");
  chk_err_mapped: assert property (acc |-> pslverr == !mapped)
    else $error("pslverr wrong");
  chk_err_idle: assert property (!acc |-> !pslverr)
    else $error("pslverr outside access");
  chk_err_rdzero: assert property (acc && pslverr && !pwrite |-> prdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  chk_rd_stands: assert property (acc |=> $stable(prdata))
    else $error("read data moved");
  chk_tx_pulse: assert property (transmit_interrupt |=> !transmit_interrupt)
    else $error("transmit pulse too long");
  chk_rx_pulse: assert property (receive_interrupt |=> !receive_interrupt)
    else $error("receive pulse too long");
  chk_tx_clk_high: assert property (transmit_interrupt && !shift_clock_oe_n |-> shift_clock_out)
    else $error("transmit irq inside clock pulse");
  chk_reset_idle: assert property (disable iff (1'b0) rst |-> serial_out_pin && shift_clock_out)
    else $error("lines not idle in reset");
  cov_tx: cover property (transmit_interrupt);
  cov_rx: cover property (receive_interrupt);
  cov_err: cover property (acc && pslverr);
endmodule // setst_checker

// ### tb/setst_peer.sv
// serial peer: clocked shift frames and uart frames
`timescale 1ns/1ps
module setst_peer (
  output reg serial_in_pin,
  output reg shift_clock_in,
  input wire serial_out_pin
);
  initial begin
    serial_in_pin = 1'b1;
    shift_clock_in = 1'b1;
  end
  // lsb first: drive on fall, sample on rise; clock idles high
  task automatic frame(input [7:0] tx, output [7:0] rx);
    integer i;
    #7;
    for (i = 0; i < 8; i++) begin
      shift_clock_in = 1'b0;
      serial_in_pin = tx[i];
      #160;
      shift_clock_in = 1'b1;
      rx[i] = serial_out_pin;
      #160;
    end
    serial_in_pin = ~tx[7];
  endtask
  // bit time for divider 1: 16 ticks of 2 clocks
  task automatic uart(input [7:0] d, input stop);
    integer i;
    #7;
    serial_in_pin = 1'b0;
    #1280;
    for (i = 0; i < 8; i++) begin
      serial_in_pin = d[i];
      #1280;
    end
    serial_in_pin = stop;
    #1280;
    serial_in_pin = 1'b1;
  endtask
endmodule // setst_peer
